/* File: rtl/stc_timer.sv */
// Timer with 16-bit or split 8-bit auto-reload, capture and control register
`include "stc_params.svh"
`default_nettype none
module stc_timer (
    // Clock and reset
    input  wire logic                  mclk_in,
    input  wire logic                  sys_rst_in,
    // Special function register port
    input  wire stc_pkg::stc_sfr_req_t sfr_req_in,
    output logic [7:0]                 sfr_rdata_out,
    // Clock select register bits and interrupt enable
    input  wire logic                  upper_byte_clock_select_in,
    input  wire logic                  lower_byte_clock_select_in,
    input  wire logic                  timer_irq_enable_in,
    // Asynchronous sources
    input  wire logic                  osc_div8_in,
    input  wire logic                  comparator0_in,
    // Interrupt request
    output logic                       timer_irq_out
);
    import stc_pkg::*;

    // ==========================================================
    // Synchronisers and sources
    logic [1:0] osc_sync_reg, cmp_sync_reg;
    logic       osc_prev_reg, cmp_prev_reg;
    logic [3:0] div_reg, div_next;
    logic       osc_tick, cmp_rise, sys_tick, alt_tick, cap_tick;
    logic [1:0] osc_sync_next, cmp_sync_next;
    logic       osc_prev_next, cmp_prev_next;

    stc_control_t ctl_reg, ctl_next;
    logic [7:0]   cnt_lo_reg, cnt_lo_next, cnt_hi_reg, cnt_hi_next;
    logic [7:0]   rl_lo_reg, rl_lo_next, rl_hi_reg, rl_hi_next;
    logic [7:0]   rdata_next;
    logic         irq_next;

    // Only the second stage feeds the edge detectors, never the first
    always_comb begin
        osc_sync_next = {osc_sync_reg[0], osc_div8_in};
        cmp_sync_next = {cmp_sync_reg[0], comparator0_in};
        osc_prev_next = osc_sync_reg[1];
        cmp_prev_next = cmp_sync_reg[1];
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            osc_sync_reg <= 2'h0;
            cmp_sync_reg <= 2'h0;
            osc_prev_reg <= 1'b0;
            cmp_prev_reg <= 1'b0;
        end else begin
            osc_sync_reg <= osc_sync_next;
            cmp_sync_reg <= cmp_sync_next;
            osc_prev_reg <= osc_prev_next;
            cmp_prev_reg <= cmp_prev_next;
        end
    end

    always_comb begin
        osc_tick = osc_sync_reg[1] & ~osc_prev_reg;
        cmp_rise = cmp_sync_reg[1] & ~cmp_prev_reg;
        sys_tick = (div_reg == 4'(`STC_SYS_DIVIDE - 1));
        div_next = sys_tick ? 4'h0 : div_reg + 4'h1;
        // Reserved code 10 behaves like 00 for the count source
        alt_tick = (ctl_reg.alt_clock_select == 2'h3) ? osc_tick : sys_tick;
        cap_tick = ctl_reg.alt_clock_select[1] ? cmp_rise : osc_tick;
    end

    // ==========================================================
    // Counter, reload, flags
    logic inc_lo, inc_hi, ovf_lo, ovf_hi, capture;
    logic [15:0] cnt16;

    // Control register write decode, shared by the flag checks
    function automatic logic is_ctl_write(input stc_sfr_req_t r);
        return r.write && (r.addr == `STC_ADDR_CONTROL);
    endfunction : is_ctl_write

    always_comb begin
        cnt16 = {cnt_hi_reg, cnt_lo_reg};
        // Per-byte clock choice; split mode shares one alternate source
        inc_lo = lower_byte_clock_select_in ? 1'b1 : alt_tick;
        inc_hi = upper_byte_clock_select_in ? 1'b1 : alt_tick;
        if (ctl_reg.split_mode_enable) begin
            inc_hi = inc_hi & ctl_reg.run_control;
        end else begin
            inc_lo = inc_lo & ctl_reg.run_control;
            inc_hi = inc_lo;
        end
        capture = ctl_reg.capture_enable & cap_tick;
        ovf_lo = inc_lo && (cnt_lo_reg == 8'hFF);
        ovf_hi = ctl_reg.split_mode_enable ? (inc_hi && cnt_hi_reg == 8'hFF)
                                           : (inc_lo && cnt16 == 16'hFFFF);

        cnt_lo_next = cnt_lo_reg;
        cnt_hi_next = cnt_hi_reg;
        rl_lo_next  = rl_lo_reg;
        rl_hi_next  = rl_hi_reg;
        ctl_next    = ctl_reg;

        if (ctl_reg.split_mode_enable) begin
            if (inc_lo) cnt_lo_next = ovf_lo ? rl_lo_reg : cnt_lo_reg + 8'h01;
            if (inc_hi) cnt_hi_next = ovf_hi ? rl_hi_reg : cnt_hi_reg + 8'h01;
        end else if (inc_lo) begin
            {cnt_hi_next, cnt_lo_next} = ovf_hi ? {rl_hi_reg, rl_lo_reg} : cnt16 + 16'h0001;
        end

        // Software writes first so hardware events override a clear
        if (sfr_req_in.write) begin
            unique case (sfr_req_in.addr)
                `STC_ADDR_CONTROL:   ctl_next = stc_control_t'(sfr_req_in.wdata);
                `STC_ADDR_RELOAD_LO: rl_lo_next = sfr_req_in.wdata;
                `STC_ADDR_RELOAD_HI: rl_hi_next = sfr_req_in.wdata;
                `STC_ADDR_COUNT_LO:  cnt_lo_next = sfr_req_in.wdata;
                `STC_ADDR_COUNT_HI:  cnt_hi_next = sfr_req_in.wdata;
                default: ;
            endcase
        end
        if (capture) begin
            rl_lo_next = cnt_lo_reg;
            rl_hi_next = cnt_hi_reg;
        end
        if (ovf_hi | capture) ctl_next.high_byte_overflow_flag = 1'b1;
        if (ovf_lo) ctl_next.low_byte_overflow_flag = 1'b1;

        // Request on each high-side event, and low overflow when enabled
        irq_next = timer_irq_enable_in &
                   ((ovf_hi | capture) | (ovf_lo & ctl_reg.low_byte_irq_enable));

        unique case (sfr_req_in.addr)
            `STC_ADDR_CONTROL:   rdata_next = ctl_next;
            `STC_ADDR_RELOAD_LO: rdata_next = rl_lo_next;
            `STC_ADDR_RELOAD_HI: rdata_next = rl_hi_next;
            `STC_ADDR_COUNT_LO:  rdata_next = cnt_lo_next;
            `STC_ADDR_COUNT_HI:  rdata_next = cnt_hi_next;
            default:             rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            div_reg       <= 4'h0;
            ctl_reg       <= stc_control_t'(`STC_RESET_VALUE);
            cnt_lo_reg    <= 8'h00;
            cnt_hi_reg    <= 8'h00;
            rl_lo_reg     <= 8'h00;
            rl_hi_reg     <= 8'h00;
            sfr_rdata_out <= 8'h00;
            timer_irq_out <= 1'b0;
        end else begin
            div_reg       <= div_next;
            ctl_reg       <= ctl_next;
            cnt_lo_reg    <= cnt_lo_next;
            cnt_hi_reg    <= cnt_hi_next;
            rl_lo_reg     <= rl_lo_next;
            rl_hi_reg     <= rl_hi_next;
            sfr_rdata_out <= rdata_next;
            timer_irq_out <= irq_next;
        end
    end

    // ==========================================================
    // Assertions
    high_flag_set_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        ovf_hi |=> ctl_reg.high_byte_overflow_flag) else $error("high flag not set on overflow");
    low_flag_set_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        ovf_lo |=> ctl_reg.low_byte_overflow_flag) else $error("low flag not set on overflow");
    flags_sticky_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (ctl_reg.high_byte_overflow_flag && !(sfr_req_in.write && sfr_req_in.addr == `STC_ADDR_CONTROL))
        |=> ctl_reg.high_byte_overflow_flag) else $error("high flag cleared by hardware");
    irq_high_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (ovf_hi && timer_irq_enable_in) |=> timer_irq_out) else $error("no request on high overflow");
    irq_low_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (ovf_lo && timer_irq_enable_in && ctl_reg.low_byte_irq_enable) |=> timer_irq_out)
        else $error("no request on low overflow");
    stop_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (!ctl_reg.run_control && !ctl_reg.split_mode_enable && !sfr_req_in.write)
        |=> $stable(cnt_lo_reg) && $stable(cnt_hi_reg)) else $error("counter moved while stopped");
    split_low_runs_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (ctl_reg.split_mode_enable && lower_byte_clock_select_in && !sfr_req_in.write
         && !(cnt_lo_reg == 8'hFF && rl_lo_reg == 8'hFF))
        |=> cnt_lo_reg != $past(cnt_lo_reg)) else $error("low byte stalled in split mode");
    reload_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (ovf_hi && !ctl_reg.split_mode_enable && !sfr_req_in.write)
        |=> {cnt_hi_reg, cnt_lo_reg} == $past({rl_hi_reg, rl_lo_reg})) else $error("reload missed");
    capture_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        capture |=> (rl_lo_reg == $past(cnt_lo_reg)) && ctl_reg.high_byte_overflow_flag)
        else $error("capture missed");
    sys_div_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        sys_tick |=> !sys_tick [*8]) else $error("divide by twelve too short");

    // ==========================================================
    // Further checks on flags, requests, sources and reload paths
    reset_clear_a: assert property (@(posedge mclk_in)
        sys_rst_in |=> (ctl_reg == stc_control_t'(`STC_RESET_VALUE)) && !timer_irq_out && (sfr_rdata_out == 8'h00))
        else $error("state not cleared by reset");

    irq_quiet_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !timer_irq_enable_in |=> !timer_irq_out)
        else $error("request while interrupts disabled");

    low_irq_mask_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (!ctl_reg.low_byte_irq_enable && !ovf_hi && !capture) |=> !timer_irq_out)
        else $error("low overflow request while masked");

    high_flag_quiet_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (!ctl_reg.high_byte_overflow_flag && !ovf_hi && !capture && !is_ctl_write(sfr_req_in))
        |=> !ctl_reg.high_byte_overflow_flag) else $error("high flag set with no event");

    low_sticky_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (ctl_reg.low_byte_overflow_flag && !is_ctl_write(sfr_req_in))
        |=> ctl_reg.low_byte_overflow_flag) else $error("low flag cleared by hardware");

    clear_race_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (ovf_lo && is_ctl_write(sfr_req_in)) |=> ctl_reg.low_byte_overflow_flag)
        else $error("clear beat a same-cycle overflow");

    wide_low_ovf_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (!ctl_reg.split_mode_enable && ovf_hi) |-> ovf_lo)
        else $error("16-bit rollover without low overflow");

    split_hi_gate_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (ctl_reg.split_mode_enable && !ctl_reg.run_control && !sfr_req_in.write)
        |=> $stable(cnt_hi_reg)) else $error("upper byte moved while stopped");

    split_shared_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (ctl_reg.split_mode_enable && ctl_reg.run_control && !lower_byte_clock_select_in
         && !upper_byte_clock_select_in) |-> (inc_lo == inc_hi))
        else $error("split bytes on different alternate clocks");

    split_lo_reload_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (ctl_reg.split_mode_enable && ovf_lo && !sfr_req_in.write)
        |=> cnt_lo_reg == $past(rl_lo_reg)) else $error("low byte reload missed");

    split_hi_reload_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (ctl_reg.split_mode_enable && ovf_hi && !sfr_req_in.write)
        |=> cnt_hi_reg == $past(rl_hi_reg)) else $error("high byte reload missed");

    run_counts_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (!ctl_reg.split_mode_enable && ctl_reg.run_control && lower_byte_clock_select_in
         && !ovf_hi && !sfr_req_in.write) |=> cnt16 == $past(cnt16) + 16'h0001)
        else $error("running counter did not advance");

    capture_off_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !ctl_reg.capture_enable |-> !capture)
        else $error("capture outside capture mode");

    capture_hi_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        capture |=> rl_hi_reg == $past(cnt_hi_reg))
        else $error("captured upper byte wrong");

    cap_osc_src_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (ctl_reg.capture_enable && !ctl_reg.alt_clock_select[1]) |-> (capture == osc_tick))
        else $error("capture not on oscillator tick");

    cap_cmp_src_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (ctl_reg.capture_enable && ctl_reg.alt_clock_select[1]) |-> (capture == cmp_rise))
        else $error("capture not on comparator edge");

    osc_sync_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        osc_tick |-> $past(osc_div8_in, 2))
        else $error("oscillator tick without synchronised input");

    cmp_sync_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        cmp_rise |-> $past(comparator0_in, 2))
        else $error("comparator edge without synchronised input");
endmodule : stc_timer
`default_nettype wire

/* File: shared/stc_params.svh */
// Constants for the split timer control block
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH
`define STC_ADDR_CONTROL   8'hC8
`define STC_ADDR_RELOAD_LO 8'hCA
`define STC_ADDR_RELOAD_HI 8'hCB
`define STC_ADDR_COUNT_LO  8'hCC
`define STC_ADDR_COUNT_HI  8'hCD
`define STC_RESET_VALUE    8'h00
`define STC_BIT_HIGH_FLAG  7
`define STC_BIT_LOW_FLAG   6
`define STC_BIT_LOW_IRQEN  5
`define STC_BIT_CAPTURE    4
`define STC_BIT_SPLIT      3
`define STC_BIT_RUN        2
`define STC_SYS_DIVIDE     12
`define STC_OSC_DIVIDE     8
`endif

/* File: shared/stc_pkg.sv */
// Types for the split timer control block
`default_nettype none
package stc_pkg;
    typedef struct packed {
        logic       high_byte_overflow_flag;
        logic       low_byte_overflow_flag;
        logic       low_byte_irq_enable;
        logic       capture_enable;
        logic       split_mode_enable;
        logic       run_control;
        logic [1:0] alt_clock_select;
    } stc_control_t;
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } stc_sfr_req_t;
endpackage : stc_pkg
`default_nettype wire

/* File: verification/split_timer_control_bench.sv */
// Self-checking bench for the split timer control block
`default_nettype none
module split_timer_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import stc_pkg::*;
    // ==========================================
    // Stimulus and observation
    logic          mclk_in    = 1'b0;
    logic          sys_rst_in = 1'b1;
    stc_sfr_req_t  req        = '0;
    logic [7:0]    rdata;
    logic          up_sel = 1'b0, lo_sel = 1'b0, irq_en = 1'b0, osc = 1'b0, cmp0 = 1'b0;
    logic          irq;
    logic [7:0]    v;
    logic [7:0]    c;
    int            error_cnt = 0;
    int            cmp_count = 0;
    always #4 mclk_in = ~mclk_in;
    stc_timer dut_u (
        .mclk_in                    (mclk_in),
        .sys_rst_in                 (sys_rst_in),
        .sfr_req_in                 (req),
        .sfr_rdata_out              (rdata),
        .upper_byte_clock_select_in (up_sel),
        .lower_byte_clock_select_in (lo_sel),
        .timer_irq_enable_in        (irq_en),
        .osc_div8_in                (osc),
        .comparator0_in             (cmp0),
        .timer_irq_out              (irq)
    );
    // ==========================================
    // Access and check tasks
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic cycles(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge mclk_in);
        req.write <= 1'b0;
    endtask : wr
    // Read data is registered: sample one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk_in);
        @(negedge mclk_in);
        d = rdata;
    endtask : rd
    task automatic wait_irq(input int bound);
        bit seen;
        seen = 1'b0;
        for (int i = 0; i < bound && !seen; i++) begin
            @(negedge mclk_in);
            seen = (irq === 1'b1);
        end
        if (!seen) begin
            error_cnt++;
            $display("MISMATCH t=%0t interrupt never came", $time);
            wrap_up();
        end
    endtask : wait_irq
    // Held four cycles so the two-flop synchroniser surely sees it
    task automatic pulse(input bit use_cmp);
        @(posedge mclk_in);
        if (use_cmp) cmp0 <= 1'b1;
        else osc <= 1'b1;
        cycles(4);
        cmp0 <= 1'b0;
        osc  <= 1'b0;
        cycles(6);
    endtask : pulse
    // ==========================================
    // Test sequence
    initial begin
        cycles(4);
        sys_rst_in <= 1'b0;
        rd(8'hC8, v); chk(v, 8'h00, "control reset");
        wr(8'hC9, 8'hFF);
        rd(8'hC9, v); chk(v, 8'h00, "unmapped");
        $display("test reset done");
        // 16-bit rollover on the divided clock
        @(posedge mclk_in); irq_en <= 1'b1;
        wr(8'hCB, 8'hAB); wr(8'hCA, 8'hF0); wr(8'hCD, 8'hFF); wr(8'hCC, 8'hFE);
        wr(8'hC8, 8'h04);
        wait_irq(100);
        rd(8'hC8, v); chk(v & 8'h80, 8'h80, "high flag");
        rd(8'hCC, v); chk(v, 8'hF0, "reload lo");
        rd(8'hCD, v); chk(v, 8'hAB, "reload hi");
        cycles(30);
        rd(8'hC8, v); chk(v & 8'h80, 8'h80, "flag held");
        wr(8'hC8, 8'h04);
        rd(8'hC8, v); chk(v & 8'hC0, 8'h00, "flag cleared");
        wr(8'hC8, 8'h00);
        $display("test rollover done");
        // Stopped timer must not move
        @(posedge mclk_in); lo_sel <= 1'b1; up_sel <= 1'b1;
        wr(8'hCD, 8'hFF); wr(8'hCC, 8'hFF);
        cycles(20);
        rd(8'hCC, v); chk(v, 8'hFF, "stopped count");
        rd(8'hC8, v); chk(v, 8'h00, "no flag when stopped");
        $display("test stop done");
        // Split mode: lower runs alone, high byte held
        wr(8'hCC, 8'hF8); wr(8'hCA, 8'h10);
        wr(8'hC8, 8'h28);
        wait_irq(50);
        rd(8'hC8, v); chk(v, 8'h68, "split flags");
        rd(8'hCD, v); chk(v, 8'hFF, "upper held");
        wr(8'hC8, 8'h00);
        $display("test split done");
        // Capture trigger per select code
        for (c = 8'h00; c < 8'h04; c++) begin
            wr(8'hCD, 8'h40 + c); wr(8'hCC, 8'h00);
            wr(8'hC8, 8'h14 | c);
            pulse(c < 8'h02);
            rd(8'hC8, v); chk(v & 8'h80, 8'h00, "wrong trigger");
            pulse(c >= 8'h02);
            rd(8'hC8, v); chk(v & 8'h80, 8'h80, "capture flag");
            rd(8'hCB, v); chk(v, 8'h40 + c, "captured hi");
            wr(8'hC8, 8'h00);
        end
        $display("test capture done");
        wrap_up();
    end
endmodule : split_timer_control_bench
`default_nettype wire
